/* File: src/acsp_pkg.sv */
package acsp_pkg;
  // Register locations
  localparam logic [7:0] ADDR_PORT_CFG   = 8'h00;
  localparam logic [7:0] ADDR_CHIP_ID    = 8'h01;
  localparam logic [7:0] ADDR_CHIP_GRADE = 8'h02;
  localparam logic [7:0] ADDR_DEV_INDEX  = 8'h05;
  localparam logic [7:0] ADDR_TRANSFER   = 8'hff;
  localparam logic [7:0] ADDR_PROG_FIRST = 8'h08;
  localparam logic [7:0] ADDR_PROG_LAST  = 8'h25;
  localparam int         PROG_DEPTH      = 30;
  // Port configuration fields, nibbles mirrored
  localparam int         CFG_LSB_HI      = 6;
  localparam int         CFG_LSB_LO      = 1;
  localparam int         CFG_SRST_HI     = 5;
  localparam int         CFG_SRST_LO     = 2;
  localparam int         XFER_BIT        = 0;
  // Values after reset
  localparam logic [7:0] CFG_FIXED_ONES  = 8'h18;
  localparam logic [7:0] GRADE_VALUE     = 8'h00;
  localparam logic [1:0] INDEX_RESET     = 2'b11;
  localparam logic [7:0] PROG_RESET      = 8'h00;
  // Instruction layout
  localparam int         INSTR_BITS      = 16;
  localparam int         BYTE_BITS       = 8;
  localparam int         RW_BIT          = 15;
  localparam int         WL_HI           = 14;
  localparam int         WL_LO           = 13;
  localparam logic [1:0] WL_STREAM       = 2'b11;
  // Cycles after reset release before the strap is caught
  localparam logic [1:0] STRAP_WAIT      = 2'd3;

  typedef enum logic [1:0] {
    ACSP_IDLE,
    ACSP_INSTR,
    ACSP_DATA,
    ACSP_PAUSE
  } acsp_state_t;
endpackage : acsp_pkg

/* File: src/acsp_port.sv */
`timescale 1ns/1ps
module acsp_port #(
  parameter logic [7:0] CHIP_ID = 8'h5a  // Arbitrary value
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Serial pins
  input  wire logic       sclk_pin,
  input  wire logic       port_select_n,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe,
  // Straps and static controls
  input  wire logic       out_tristate_strap,
  output logic            powerdown,
  output logic            data_out_en,
  output logic            static_mode,
  // Active program settings for the datapath
  input  wire logic [7:0] cfg_addr,
  output logic [7:0]      cfg_a,
  output logic [7:0]      cfg_b,
  output logic            xfer_done
);
  import acsp_pkg::*;

  acsp_state_t state_reg;
  logic [2:0]  sclk_s;
  logic [2:0]  csn_s;
  logic [1:0]  sdio_s;
  logic [1:0]  oe_s;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        csn_rise;
  logic        csn_fall;
  logic        csn_low;
  logic [3:0]  cnt_reg;
  logic [15:0] instr_reg;
  logic [15:0] instr_next;
  logic [7:0]  rx_reg;
  logic [7:0]  rx_next;
  logic [7:0]  tx_reg;
  logic [7:0]  addr_reg;
  logic [7:0]  addr_step;
  logic [1:0]  left_reg;
  logic        stream_reg;
  logic        read_reg;
  logic        wr_stb;
  logic        lsb_reg;
  logic        soft_reg;
  logic        xfer_reg;
  logic [1:0]  index_reg;
  logic [1:0]  strap_cnt;
  logic        strap_reg;
  logic [7:0]  pend_a [PROG_DEPTH];
  logic [7:0]  pend_b [PROG_DEPTH];
  logic [7:0]  act_a  [PROG_DEPTH];
  logic [7:0]  act_b  [PROG_DEPTH];

  // Pins cross into clk; edges found by comparing the second and third stages
  always_ff @(posedge clk) begin
    sclk_s <= {sclk_s[1:0], sclk_pin};
    csn_s  <= {csn_s[1:0], port_select_n};
    sdio_s <= {sdio_s[0], sdio_in};
    oe_s   <= {oe_s[0], out_tristate_strap};
  end

  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2];
  assign csn_rise  = csn_s[1] & ~csn_s[2];
  assign csn_fall  = ~csn_s[1] & csn_s[2];
  assign csn_low   = ~csn_s[1];

  function automatic logic in_prog(input logic [7:0] a);
    in_prog = (a >= ADDR_PROG_FIRST) && (a <= ADDR_PROG_LAST);
  endfunction : in_prog

  function automatic logic [4:0] prog_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_PROG_FIRST;
    prog_idx = d[4:0];
  endfunction : prog_idx

  // Undefined locations read as zero
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    read_byte = 8'h00;
    if (in_prog(a)) begin
      if (index_reg[0]) begin
        read_byte = pend_a[prog_idx(a)];
      end else if (index_reg[1]) begin
        read_byte = pend_b[prog_idx(a)];
      end
    end else begin
      case (a)
        ADDR_PORT_CFG:   read_byte = CFG_FIXED_ONES | {1'b0, lsb_reg, 4'h0, lsb_reg, 1'b0};
        ADDR_CHIP_ID:    read_byte = CHIP_ID;
        ADDR_CHIP_GRADE: read_byte = GRADE_VALUE;
        ADDR_DEV_INDEX:  read_byte = {6'h00, index_reg};
        ADDR_TRANSFER:   read_byte = {7'h00, xfer_reg};
        default:         read_byte = 8'h00;
      endcase
    end
  endfunction : read_byte

  // Shift order follows the configuration
  assign instr_next = lsb_reg ? {sdio_s[1], instr_reg[15:1]}
                              : {instr_reg[14:0], sdio_s[1]};
  assign rx_next    = lsb_reg ? {sdio_s[1], rx_reg[7:1]}
                              : {rx_reg[6:0], sdio_s[1]};
  assign addr_step  = lsb_reg ? addr_reg + 8'h01 : addr_reg - 8'h01;
  assign wr_stb     = sclk_rise && csn_low && (state_reg == ACSP_DATA) &&
                      (cnt_reg == 4'(BYTE_BITS - 1)) && !read_reg;

  // Frame engine
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg  <= ACSP_IDLE;
      cnt_reg    <= 4'h0;
      instr_reg  <= 16'h0000;
      rx_reg     <= 8'h00;
      tx_reg     <= 8'h00;
      addr_reg   <= 8'h00;
      left_reg   <= 2'b00;
      stream_reg <= 1'b0;
      read_reg   <= 1'b0;
    end else if (csn_rise) begin
      // A stall is legal only on a byte boundary of a counted frame
      if (state_reg == ACSP_DATA && cnt_reg == 4'h0 && !stream_reg) begin
        state_reg <= ACSP_PAUSE;
      end else begin
        state_reg <= ACSP_IDLE;
      end
    end else begin
      case (state_reg)
        ACSP_IDLE: begin
          if (csn_fall) begin
            state_reg <= ACSP_INSTR;
            cnt_reg   <= 4'h0;
          end
        end
        ACSP_PAUSE: begin
          if (csn_fall) begin
            state_reg <= ACSP_DATA;
          end
        end
        ACSP_INSTR: begin
          if (sclk_rise && csn_low) begin
            instr_reg <= instr_next;
            cnt_reg   <= cnt_reg + 4'h1;
            if (cnt_reg == 4'(INSTR_BITS - 1)) begin
              state_reg  <= ACSP_DATA;
              cnt_reg    <= 4'h0;
              read_reg   <= instr_next[RW_BIT];
              left_reg   <= instr_next[WL_HI:WL_LO];
              stream_reg <= (instr_next[WL_HI:WL_LO] == WL_STREAM);
              addr_reg   <= instr_next[7:0];
              tx_reg     <= read_byte(instr_next[7:0]);
            end
          end
        end
        ACSP_DATA: begin
          if (sclk_rise && csn_low) begin
            rx_reg  <= rx_next;
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == 4'(BYTE_BITS - 1)) begin
              cnt_reg  <= 4'h0;
              addr_reg <= addr_step;
              tx_reg   <= read_byte(addr_step);
              if (!stream_reg) begin
                if (left_reg == 2'b00) begin
                  state_reg <= ACSP_IDLE;
                end else begin
                  left_reg <= left_reg - 2'b01;
                end
              end
            end
          end
        end
        default: state_reg <= ACSP_IDLE;
      endcase
    end
  end

  // Data pin turnaround: bits launched on the falling edge
  always_ff @(posedge clk) begin
    if (srst || static_mode) begin
      sdio_oe  <= 1'b0;
      sdio_out <= 1'b0;
    end else if (!csn_low || state_reg != ACSP_DATA || !read_reg) begin
      sdio_oe <= 1'b0;
    end else if (sclk_fall) begin
      sdio_oe  <= 1'b1;
      sdio_out <= lsb_reg ? tx_reg[cnt_reg[2:0]] : tx_reg[3'd7 - cnt_reg[2:0]];
    end
  end

  // Chip configuration and index registers
  always_ff @(posedge clk) begin
    if (srst || soft_reg) begin
      lsb_reg   <= 1'b0;
      index_reg <= INDEX_RESET;
      soft_reg  <= 1'b0;
      xfer_reg  <= 1'b0;
    end else begin
      xfer_reg <= 1'b0;
      if (wr_stb) begin
        case (addr_reg)
          ADDR_PORT_CFG: begin
            lsb_reg  <= rx_next[CFG_LSB_HI] | rx_next[CFG_LSB_LO];
            soft_reg <= rx_next[CFG_SRST_HI] | rx_next[CFG_SRST_LO];
          end
          ADDR_DEV_INDEX: index_reg <= rx_next[1:0];
          ADDR_TRANSFER:  xfer_reg  <= rx_next[XFER_BIT];
          default: ;
        endcase
      end
    end
  end

  // Shadowed program registers, copied to active on transfer
  always_ff @(posedge clk) begin
    if (srst || soft_reg) begin
      for (int i = 0; i < PROG_DEPTH; i++) begin
        pend_a[i] <= PROG_RESET;
        pend_b[i] <= PROG_RESET;
        act_a[i]  <= PROG_RESET;
        act_b[i]  <= PROG_RESET;
      end
    end else begin
      if (wr_stb && in_prog(addr_reg)) begin
        if (index_reg[0]) begin
          pend_a[prog_idx(addr_reg)] <= rx_next;
        end
        if (index_reg[1]) begin
          pend_b[prog_idx(addr_reg)] <= rx_next;
        end
      end
      if (xfer_reg) begin
        for (int i = 0; i < PROG_DEPTH; i++) begin
          act_a[i] <= pend_a[i];
          act_b[i] <= pend_b[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_a     <= 8'h00;
      cfg_b     <= 8'h00;
      xfer_done <= 1'b0;
    end else begin
      xfer_done <= xfer_reg;
      cfg_a     <= in_prog(cfg_addr) ? act_a[prog_idx(cfg_addr)] : 8'h00;
      cfg_b     <= in_prog(cfg_addr) ? act_b[prog_idx(cfg_addr)] : 8'h00;
    end
  end

  // Static mode lasts until the first chip select fall after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      static_mode <= 1'b1;
      strap_cnt   <= 2'd0;
      strap_reg   <= 1'b1;
      powerdown   <= 1'b1;
      data_out_en <= 1'b0;
    end else begin
      if (csn_fall) begin
        static_mode <= 1'b0;
      end
      // Wait for the synchroniser to fill before catching the strap
      if (strap_cnt != STRAP_WAIT) begin
        strap_cnt <= strap_cnt + 2'd1;
        strap_reg <= 1'b1;
      end else if (strap_cnt == STRAP_WAIT && static_mode && state_reg == ACSP_IDLE) begin
        strap_reg <= sdio_s[1];
      end
      powerdown   <= static_mode & strap_reg;
      data_out_en <= ~oe_s[1];
    end
  end
endmodule : acsp_port

/* File: verification/acsp_port_sva.sv */
`timescale 1ns/1ps
module acsp_port_sva (
  // Clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // Serial pins
  input wire logic       sclk_pin,
  input wire logic       port_select_n,
  input wire logic       sdio_in,
  input wire logic       sdio_out,
  input wire logic       sdio_oe,
  // Straps and settings
  input wire logic       out_tristate_strap,
  input wire logic       powerdown,
  input wire logic       data_out_en,
  input wire logic       static_mode,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_a,
  input wire logic [7:0] cfg_b,
  input wire logic       xfer_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  reset_state_a: assert property (
    $fell(srst) |-> static_mode && !sdio_oe && cfg_a == 8'h00) else $error("reset state");
  idle_quiet_a: assert property (
    port_select_n [*6] |-> !sdio_oe) else $error("drives while deselected");
  select_release_a: assert property (
    $rose(port_select_n) |-> ##[1:5] !sdio_oe) else $error("pin not released");
  static_quiet_a: assert property (
    static_mode |-> !sdio_oe) else $error("drives in static mode");
  strap_high_a: assert property (
    out_tristate_strap [*5] |-> !data_out_en) else $error("outputs not off");
  strap_low_a: assert property (
    !out_tristate_strap [*5] |-> data_out_en) else $error("outputs not on");
  pd_strap_a: assert property (
    (static_mode && sdio_in) [*6] |-> powerdown) else $error("no power-down");
  pd_used_a: assert property (
    !static_mode && !$past(static_mode) |-> !powerdown) else $error("power-down in use");
  xfer_pulse_a: assert property (
    xfer_done |=> !xfer_done) else $error("long transfer pulse");
  cfg_range_a: assert property (
    cfg_addr < 8'h08 || cfg_addr > 8'h25 |=> cfg_a == 8'h00 && cfg_b == 8'h00)
    else $error("value outside range");
endmodule : acsp_port_sva

/* File: verification/acsp_host.sv */
`timescale 1ns/1ps
module acsp_host (
  // Clock
  input  wire logic  clk,
  // Device side
  input  wire logic  sdio_out,
  input  wire logic  sdio_oe,
  output logic       sclk_pin,
  output logic       port_select_n,
  output logic       sdio_line,
  // Read results
  output logic [7:0] rd_byte
);
  // Shift order in use; the bench flips it after it changes the port's order
  logic lsb_mode = 1'b0;
  logic host_oe = 1'b1;
  logic host_do = 1'b1;
  int   rd_cnt  = 0;
  initial begin
    sclk_pin = 1'b0;
    port_select_n = 1'b1;
    rd_byte = 8'h00;
  end
  // A released line shows the inverse of its last level, never a kind default
  assign sdio_line = sdio_oe ? sdio_out : (host_oe ? host_do : ~host_do);
  task automatic half();
    repeat (10) @(negedge clk);
  endtask : half
  task automatic bit_io(input logic rd, input logic v, output logic got);
    host_oe = ~rd;
    host_do = v;
    half();
    sclk_pin = 1'b1;
    got = sdio_line;
    half();
    sclk_pin = 1'b0;
  endtask : bit_io
  task automatic frame(input logic rw, input logic [1:0] wl, input logic [7:0] addr,
                       input int n, input logic [15:0] wd, input logic pause);
    logic [15:0] ins;
    logic [7:0]  b;
    logic [7:0]  w;
    logic        g;
    int          p;
    ins = {rw, wl, 5'h00, addr};
    port_select_n = 1'b0;
    half();
    // In LSB mode the whole instruction goes address end first
    for (int i = 0; i < 16; i++) bit_io(1'b0, ins[lsb_mode ? i : 15 - i], g);
    for (int k = 0; k < n; k++) begin
      if (pause && k > 0) begin
        port_select_n = 1'b1;
        half();
        port_select_n = 1'b0;
        half();
      end
      // Bytes past the first all carry the low byte of wd so the line never shows unknowns
      w = (k == 0) ? wd[15:8] : wd[7:0];
      for (int i = 0; i < 8; i++) begin
        p = lsb_mode ? i : 7 - i;
        bit_io(rw, w[p], g);
        b[p] = g;
      end
      rd_byte = b;
      if (rw) rd_cnt++;
    end
    half();
    // Serial clock stays still and select high between frames
    port_select_n = 1'b1;
    half();
    host_oe = 1'b1;
    host_do = 1'b1;
    half();
  endtask : frame
endmodule : acsp_host

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import acsp_pkg::*;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       strap = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic       sclk, csn, sdio_line, sdio_out, sdio_oe, pd, doe, stat, xd;
  logic [7:0] cfg_a, cfg_b, rd_byte, d, e, n0;
  logic [7:0] xd_cnt = 8'h00;
  logic [7:0] exp_q[$];
  int         num_errors = 0;
  int         cmp_count = 0;
  integer     seed = 32'he6302d39;
  initial forever #4 clk = ~clk;
  acsp_port #(.CHIP_ID(8'h3c)) i_dut (.clk(clk), .srst(srst), .sclk_pin(sclk),
    .port_select_n(csn), .sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .out_tristate_strap(strap), .powerdown(pd), .data_out_en(doe), .static_mode(stat),
    .cfg_addr(cfg_addr), .cfg_a(cfg_a), .cfg_b(cfg_b), .xfer_done(xd));
  acsp_host i_host (.clk(clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sclk_pin(sclk),
    .port_select_n(csn), .sdio_line(sdio_line), .rd_byte(rd_byte));
  always @(posedge clk) if (xd === 1'b1) xd_cnt <= xd_cnt + 8'h01;
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8
  task automatic end_of_test();
    $display("errors %0d of %0d compares", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    i_host.frame(1'b1, 2'b00, a, 1, 16'h0000, 1'b0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_host.frame(1'b0, 2'b00, a, 1, {v, 8'h00}, 1'b0);
  endtask : wr
  task automatic xfer();
    n0 = xd_cnt;
    wr(ADDR_TRANSFER, 8'h01);
    check8(xd_cnt - n0, 8'h01);
  endtask : xfer
  task automatic look(input logic [7:0] a, input logic [7:0] xa, input logic [7:0] xb);
    cfg_addr = a;
    repeat (2) @(negedge clk);
    check8(cfg_a, xa);
    check8(cfg_b, xb);
  endtask : look
  initial forever begin
    @(i_host.rd_cnt);
    check8(rd_byte, exp_q.pop_front());
  end
  initial begin
    #400000;
    num_errors++;
    end_of_test();
  end
  initial begin
    {strap, d, e} = 17'($random(seed));
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (8) @(negedge clk);
    check8({stat, pd, doe}, {2'b11, ~strap});
    rd(ADDR_CHIP_ID, 8'h3c);
    rd(ADDR_CHIP_GRADE, GRADE_VALUE);
    rd(ADDR_DEV_INDEX, {6'h00, INDEX_RESET});
    rd(ADDR_PORT_CFG, CFG_FIXED_ONES);
    rd(8'h13, 8'h00);
    check8({stat, pd}, 2'b00);
    exp_q.push_back(8'h3c);
    exp_q.push_back(CFG_FIXED_ONES);
    i_host.frame(1'b1, 2'b01, ADDR_CHIP_ID, 2, 16'h0000, 1'b0);
    wr(ADDR_PROG_FIRST, d);
    look(ADDR_PROG_FIRST, PROG_RESET, PROG_RESET);
    xfer();
    look(ADDR_PROG_FIRST, d, d);
    rd(ADDR_PROG_FIRST, d);
    wr(ADDR_DEV_INDEX, 8'h02);
    i_host.frame(1'b0, 2'b01, 8'h09, 2, {e, ~e}, 1'b1);
    xfer();
    look(8'h09, PROG_RESET, e);
    look(ADDR_PROG_FIRST, d, ~e);
    rd(8'h09, e);
    exp_q.push_back(GRADE_VALUE);
    exp_q.push_back(8'h3c);
    exp_q.push_back(CFG_FIXED_ONES);
    i_host.frame(1'b1, WL_STREAM, ADDR_CHIP_GRADE, 3, 16'h0000, 1'b0);
    wr(ADDR_PORT_CFG, 8'h42);
    i_host.lsb_mode = 1'b1;
    exp_q.push_back(CFG_FIXED_ONES | 8'h42);
    exp_q.push_back(8'h3c);
    i_host.frame(1'b1, 2'b01, ADDR_PORT_CFG, 2, 16'h0000, 1'b0);
    // Soft reset with the order bits set: the reload must win
    wr(ADDR_PORT_CFG, 8'h66);
    i_host.lsb_mode = 1'b0;
    look(ADDR_PROG_FIRST, PROG_RESET, PROG_RESET);
    rd(ADDR_PORT_CFG, CFG_FIXED_ONES);
    rd(ADDR_DEV_INDEX, {6'h00, INDEX_RESET});
    strap = ~strap;
    repeat (8) @(negedge clk);
    check8({7'h00, doe}, {7'h00, ~strap});
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (8) @(negedge clk);
    check8({stat, pd}, 2'b11);
    rd(ADDR_DEV_INDEX, {6'h00, INDEX_RESET});
    repeat (4) @(negedge clk);
    end_of_test();
  end
endmodule : testbench
bind acsp_port acsp_port_sva i_sva (.clk(clk), .srst(srst), .sclk_pin(sclk_pin),
  .port_select_n(port_select_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
  .out_tristate_strap(out_tristate_strap), .powerdown(powerdown), .data_out_en(data_out_en),
  .static_mode(static_mode), .cfg_addr(cfg_addr), .cfg_a(cfg_a), .cfg_b(cfg_b),
  .xfer_done(xfer_done));
